// file: rtl/motor_run_regs.vh
// Register offsets, field layouts, reset values and timing counts of the run-input block.
// Assumes a 32-bit AXI4-Lite register port and a 50 MHz system clock.
//
// Functional notes
// - Each of the nine input terminals has a polarity bit: zero passes the sensed state, one inverts it, all reset to zero.
// - An input counts as ON while current flows in its isolated input element, whatever the pin voltage.
// - In speed control, turning a run input ON rotates the motor at the speed of the selected data entry.
// - In speed control, turning OFF the run input that is ON decelerates the motor to a stop.
// - The direction bit picks positive rotation: zero makes counterclockwise positive, one clockwise, reset one.
// - In position control, a run input ON starts continuous operation at the selected entry's speed; after a run the code restarts only in its direction.
// - In continuous operation, forward drives the positive direction and reverse the negative one.
// - Reasserting the same-direction run input while decelerating makes the motor accelerate and continue.
// - Forward and reverse both ON or both OFF decelerate the motor to a stop.
// - The active data entry is chosen from the ON/OFF pattern of the four data select inputs.
`ifndef MOTOR_RUN_REGS_VH
`define MOTOR_RUN_REGS_VH

`define OFS_POLARITY 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_SPEED_BASE 8'h40

`define RST_POLARITY 9'h000
`define RST_DIRECTION 1'h1
`define RST_CONTROL 1'h0

`define BIT_DIRECTION 0
`define BIT_POSMODE 0
`define STS_RUNNING 0
`define STS_DECEL 1
`define STS_DIR 2
`define STS_SEL 4
`define STS_FWD 8
`define STS_RVS 9
`define STS_TERM 16

`define CLK_HZ 50000000
`define HOLD_MS 10
`define HOLD_CYCLES ((`CLK_HZ / 1000) * `HOLD_MS)

`endif

// file: rtl/speed_table.v
// Operation speed memory: sixteen entries written by software, registered read port.
// Assumes one clock; one write and one read address per cycle.
`timescale 1ns/10ps
module speed_table #(
  parameter WIDTH = 16,
  parameter ABITS = 4
) (
  input wire clk_sys, // System clock
  input wire writeEn, // Write strobe
  input wire [ABITS-1:0] writeAddr, // Write entry
  input wire [WIDTH-1:0] writeData, // Write value
  input wire [ABITS-1:0] readAddr, // Read entry
  output reg [WIDTH-1:0] readData // Registered read value
);
  reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

  always @(posedge clk_sys) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule // speed_table

// file: rtl/motor_run_input_logic.v
// Input conditioning, data select and run-command logic of the motor driver, with an AXI4-Lite
// register port. Assumes terminal levels arrive asynchronously from the isolated input elements.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "motor_run_regs.vh"
module motor_run_input_logic #(
  parameter HOLD_CYCLES = `HOLD_CYCLES,
  parameter SPEED_W = 16
) (
  input wire clk_sys, // System clock, 50 MHz
  input wire rst_b, // Asynchronous reset, active low
  input wire [8:0] inputTerminals, // High while current flows in the input element
  input wire [3:0] forwardSlot, // Terminal index of the forward run input
  input wire [3:0] reverseSlot, // Terminal index of the reverse run input
  input wire [3:0] selectSlot, // Terminal index of data select input 0, three more follow
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  output reg [1:0] s_axi_bresp, // Write response
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  input wire [7:0] s_axi_araddr, // Read address
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg motorRun, // Motor commanded to rotate or decelerate
  output reg motorCw, // Physical rotation is clockwise
  output reg [SPEED_W-1:0] targetSpeed, // Speed command, zero while decelerating
  output reg decelerating // Run input dropped, ramping down
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DECEL = 3'b100;
  // Filter counter sized from the hold count, so the 10 ms default fits
  localparam HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam [31:0] HOLD_LAST = HOLD_CYCLES - 1;
  localparam [31:0] HOLD_ONE = 32'h00000001;

  reg [8:0] syncA;
  reg [8:0] syncB;
  reg [8:0] polarity;
  reg direction;
  reg posMode;
  reg [2:0] state;
  reg runDir;
  wire [8:0] term;
  reg awTaken;
  reg wTaken;
  reg [7:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire [SPEED_W-1:0] selSpeed;
  wire [3:0] dataSel;
  reg fwdOn;
  reg rvsOn;
  reg [2:0] next_state;
  reg next_runDir;
  wire doWrite;
  wire speedWrite;

  // Two-stage synchroniser on the terminal levels
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncA <= 9'h000;
      syncB <= 9'h000;
    end else begin
      syncA <= inputTerminals;
      syncB <= syncA;
    end
  end

  // Inversion then a qualification filter per terminal
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : gTerm
      reg [HOLD_W-1:0] holdCnt;
      reg termQ;
      wire level = syncB[g] ^ polarity[g];
      assign term[g] = termQ;
      // A level must stand HOLD_CYCLES edges before it is taken; shorter pulses are dropped
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          holdCnt <= {HOLD_W{1'b0}};
          termQ <= 1'b0;
        end else if (level == termQ) begin
          holdCnt <= {HOLD_W{1'b0}};
        end else if (holdCnt >= HOLD_LAST[HOLD_W-1:0]) begin
          holdCnt <= {HOLD_W{1'b0}};
          termQ <= level;
        end else begin
          holdCnt <= holdCnt + HOLD_ONE[HOLD_W-1:0];
        end
      end
    end
  endgenerate

  // Decode run inputs and data select from the conditioned terminals
  always @* begin
    fwdOn = (forwardSlot < 4'h9) ? term[forwardSlot] : 1'b0;
    rvsOn = (reverseSlot < 4'h9) ? term[reverseSlot] : 1'b0;
  end

  // Select bit k sits k terminals above selectSlot; past the last terminal it reads OFF
  generate
    for (g = 0; g < 4; g = g + 1) begin : gSel
      localparam [4:0] STEP = g;
      wire [4:0] slot = {1'b0, selectSlot} + STEP;
      assign dataSel[g] = (slot < 5'h09) ? term[slot[3:0]] : 1'b0;
    end
  endgenerate

  // Run state machine
  always @* begin
    next_state = state;
    next_runDir = runDir;
    case (state)
      ST_IDLE: begin
        if (fwdOn != rvsOn) begin
          next_state = ST_RUN;
          next_runDir = fwdOn;
        end
      end
      ST_RUN: begin
        if (fwdOn == rvsOn) begin
          next_state = ST_DECEL;
        end else if (fwdOn != runDir) begin
          next_state = ST_DECEL;
        end
      end
      // No exit to idle: once started, the machine stays in run or decel until reset
      ST_DECEL: begin
        if (fwdOn != rvsOn && fwdOn == runDir) begin
          next_state = ST_RUN;
        end else if (fwdOn != rvsOn && !posMode) begin
          next_state = ST_RUN;
          next_runDir = fwdOn;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      runDir <= 1'b1;
      motorRun <= 1'b0;
      motorCw <= 1'b0;
      targetSpeed <= {SPEED_W{1'b0}};
      decelerating <= 1'b0;
    end else begin
      state <= next_state;
      runDir <= next_runDir;
      // Outputs follow the next state so they change in step with it
      motorRun <= next_state != ST_IDLE;
      // Forward is positive; direction bit one makes positive clockwise
      motorCw <= ~(next_runDir ^ direction);
      targetSpeed <= (next_state == ST_RUN) ? selSpeed : {SPEED_W{1'b0}};
      decelerating <= next_state == ST_DECEL;
    end
  end

  // AXI4-Lite write path
  // Apply a write once both halves are in and the last response has been taken
  assign doWrite = awTaken && wTaken && !s_axi_bvalid;
  assign speedWrite = doWrite && awAddr[7:6] == 2'b01;

  // Speed of the selected entry, one cycle behind dataSel
  speed_table #(
    .WIDTH(SPEED_W),
    .ABITS(4)
  ) uTable (
    .clk_sys(clk_sys),
    .writeEn(speedWrite),
    .writeAddr(awAddr[5:2]),
    .writeData(wData[SPEED_W-1:0]),
    .readAddr(dataSel),
    .readData(selSpeed)
  );

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      awTaken <= 1'b0;
      wTaken <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      polarity <= `RST_POLARITY;
      direction <= `RST_DIRECTION;
      posMode <= `RST_CONTROL;
    end else begin
      // Readies pulse for one cycle, so a held valid is taken on alternate cycles
      s_axi_awready <= !awTaken && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wTaken && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awTaken <= 1'b0;
        wTaken <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awAddr)
          `OFS_POLARITY: begin
            if (wStrb[0]) begin
              polarity[7:0] <= wData[7:0];
            end
            if (wStrb[1]) begin
              polarity[8] <= wData[8];
            end
          end
          `OFS_DIRECTION: begin
            if (wStrb[0]) begin
              direction <= wData[`BIT_DIRECTION];
            end
          end
          `OFS_CONTROL: begin
            if (wStrb[0]) begin
              posMode <= wData[`BIT_POSMODE];
            end
          end
          default: begin
            // Speed entries are write-only; status and unmapped offsets answer SLVERR
            if (!speedWrite) begin
              s_axi_bresp <= 2'b10;
            end
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  reg [31:0] next_rdata;
  reg next_rerr;
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `OFS_POLARITY: begin
        next_rdata[8:0] = polarity;
      end
      `OFS_DIRECTION: begin
        next_rdata[`BIT_DIRECTION] = direction;
      end
      `OFS_CONTROL: begin
        next_rdata[`BIT_POSMODE] = posMode;
      end
      `OFS_STATUS: begin
        next_rdata[`STS_RUNNING] = state != ST_IDLE;
        next_rdata[`STS_DECEL] = state == ST_DECEL;
        next_rdata[`STS_DIR] = runDir;
        next_rdata[`STS_SEL+3:`STS_SEL] = dataSel;
        next_rdata[`STS_FWD] = fwdOn;
        next_rdata[`STS_RVS] = rvsOn;
        next_rdata[`STS_TERM+8:`STS_TERM] = term;
      end
      default: begin
        next_rerr = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      // One read at a time: no accept while the answer still stands
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // motor_run_input_logic

// file: test/motor_run_checker.sv
// Port assertions of the run-input block.
// Assumes it is bound into motor_run_input_logic.
`timescale 1ns/10ps
module motor_run_checker #(
  parameter SPEED_W = 16
) (
  input wire clk_sys, // Clock
  input wire rst_b, // Reset
  input wire s_axi_arvalid, // AR valid
  input wire s_axi_arready, // AR ready
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire [31:0] s_axi_rdata, // R data
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire motorRun, // Running
  input wire decelerating, // Ramping down
  input wire [SPEED_W-1:0] targetSpeed // Speed command
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_SPEED_RUN: assert property (targetSpeed != 0 |-> motorRun && !decelerating)
    else $error("speed while not running");
  AST_DECEL_ZERO: assert property (decelerating |-> targetSpeed == 0 && motorRun)
    else $error("speed while decelerating");
  AST_RUN_HOLD: assert property (motorRun |=> motorRun)
    else $error("run dropped without stop");
  AST_START_RUN: assert property ($rose(motorRun) |-> !decelerating)
    else $error("start in decel");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule // motor_run_checker

bind motor_run_input_logic motor_run_checker #(.SPEED_W(SPEED_W)) chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .motorRun(motorRun),
  .decelerating(decelerating), .targetSpeed(targetSpeed));

// file: test/terminal_source.sv
// Far-side model: relays driving the nine input terminals.
// Assumes the bench requests levels; each level is held long enough.
`timescale 1ns/10ps
module terminal_source #(
  parameter HOLD = 4
) (
  input wire clk_sys, // Clock
  input wire [8:0] want, // Requested levels
  output reg [8:0] pins // High while current flows
);
  integer age = 0;
  initial pins = 9'h000;
  always @(posedge clk_sys) begin
    age <= age + 1;
    if (want !== pins && age > 2 * HOLD) begin
      pins <= want;
      age <= 0;
    end
  end
endmodule // terminal_source

// file: test/motor_run_input_logic_tb.sv
// Bench of the run-input block: bus master, reference model, terminal source.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "motor_run_regs.vh"
module motor_run_input_logic_tb;
  localparam HOLD = 4;
  reg clk_sys = 0;
  reg rst_b = 0;
  reg [8:0] want = 0;
  wire [8:0] pins;
  reg awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  reg [7:0] awAddr = 0, arAddr = 0;
  reg [31:0] wData = 0;
  wire awReady, wReady, bValid, arReady, rValid, motorRun, motorCw, decelerating;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [15:0] targetSpeed;
  integer errCount = 0, checked = 0, st = 0, rdir = 0, dirBit = 1, pos = 0, i;
  reg [8:0] pol = 0;
  reg [31:0] seed = 32'h83dc5b37;
  reg [15:0] sp [0:15];
  always #10 clk_sys = ~clk_sys;
  terminal_source #(.HOLD(HOLD)) src (.clk_sys(clk_sys), .want(want), .pins(pins));
  motor_run_input_logic #(.HOLD_CYCLES(HOLD), .SPEED_W(16)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .inputTerminals(pins),
    .forwardSlot(4'h0), .reverseSlot(4'h1), .selectSlot(4'h2),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .motorRun(motorRun), .motorCw(motorCw), .targetSpeed(targetSpeed),
    .decelerating(decelerating));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task cmp(input string n, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        errCount = errCount + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg pa, pw;
    begin
      awAddr <= a;
      wData <= d;
      awValid <= 1;
      wValid <= 1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
        @(posedge clk_sys);
        if (pa && awReady) begin
          pa = 0;
          awValid <= 0;
        end
        if (pw && wReady) begin
          pw = 0;
          wValid <= 0;
        end
      end
      bReady <= 1;
      do @(posedge clk_sys); while (!bValid);
      cmp("bresp", er, bResp);
      bReady <= 0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      arAddr <= a;
      arValid <= 1;
      do @(posedge clk_sys); while (!arReady);
      arValid <= 0;
      rReady <= 1;
      do @(posedge clk_sys); while (!rValid);
      cmp("rresp", er, rResp);
      if (er == 0) cmp("rdata", ed, rData);
      rReady <= 0;
    end
  endtask
  // Drive one run pattern with a random data number, update the model, compare
  task step(input f, input r);
    reg [3:0] sel;
    begin
      seed = xs(seed);
      sel = seed[3:0];
      want <= {seed[8:6], sel, r, f} ^ pol;
      if (f ^ r) begin
        if (st == 0 || (st == 1 && rdir == f) || (st == 2 && (rdir == f || !pos))) begin
          st = 1;
          rdir = f;
        end else st = 2;
      end else if (st != 0) st = 2;
      repeat (3 * HOLD + 12) @(posedge clk_sys);
      cmp("run", st != 0, motorRun);
      cmp("decel", st == 2, decelerating);
      cmp("speed", st == 1 ? sp[sel] : 0, targetSpeed);
      if (st == 1) cmp("cw", rdir == dirBit, motorCw);
    end
  endtask
  task runSeq(input [15:0] c, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) step(c[2*k], c[2*k+1]);
  endtask
  task endOfTest;
    begin
      $display("checked %0d errCount %0d", checked, errCount);
      if (errCount == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount = errCount + 1;
    endOfTest;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1;
    rd(`OFS_POLARITY, 32'h0, 2'h0);
    rd(`OFS_DIRECTION, 32'h1, 2'h0);
    rd(8'h80, 32'h0, 2'h2);
    wr(8'h80, 32'h0, 2'h2);
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      sp[i] = seed[15:0] | 16'h1;
      wr(`OFS_SPEED_BASE + {i[5:0], 2'h0}, {16'h0, sp[i]}, 2'h0);
    end
    // Ends with both inputs ON, so the inversion below keeps fwd equal to rvs
    runSeq({2'd3, 2'd2, 2'd2, 2'd3, 2'd1, 2'd0, 2'd1}, 7);
    pol = 9'h1ff;
    wr(`OFS_POLARITY, 32'h1ff, 2'h0);
    runSeq({2'd1, 2'd1}, 2);
    dirBit = 0;
    wr(`OFS_DIRECTION, 32'h0, 2'h0);
    runSeq({2'd2, 2'd0, 2'd1}, 3);
    pos = 1;
    wr(`OFS_CONTROL, 32'h1, 2'h0);
    runSeq({2'd1, 2'd2, 2'd1, 2'd0}, 4);
    rd(`OFS_POLARITY, 32'h1ff, 2'h0);
    rd(`OFS_CONTROL, 32'h1, 2'h0);
    rd(`OFS_SPEED_BASE, 32'h0, 2'h2);
    endOfTest;
  end
endmodule // motor_run_input_logic_tb
